// *** logic/ccu_cfg.svh ***
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

// Register indexes, byte address is four times the index
`define CCU_IDX_FLAGS     8'h0c
`define CCU_IDX_VAL_LO    8'h15
`define CCU_IDX_VAL_HI    8'h16
`define CCU_IDX_CTRL      8'h17
`define CCU_IDX_PINCFG    8'h20
`define CCU_IDX_ENABLES   8'h8c

// Reset values
`define CCU_RST_FLAGS     8'h00
`define CCU_RST_CTRL      8'h00
`define CCU_RST_ENABLES   8'h00
`define CCU_RST_VALUE     16'h0000
`define CCU_RST_PINCFG    8'h0c

// Field positions
`define CCU_FLAG_BIT      2
`define CCU_FLAGS_MASK    8'h4f
`define CCU_ENABLES_MASK  8'h4f
`define CCU_CTRL_MASK     8'h3f
`define CCU_DUTY_LSB      4
`define CCU_PIN_SEL_BIT   0
`define CCU_DIR2_BIT      2
`define CCU_DIR3_BIT      3
`define CCU_DAT2_BIT      4
`define CCU_DAT3_BIT      5
`define CCU_PINCFG_MASK   8'h3d

// Capture prescale terminal counts
`define CCU_PS4_LAST      2'h3
`define CCU_PS16_LAST     4'hf

`endif

// *** logic/ccu_pkg.sv ***
package ccu_pkg;

  typedef enum logic [3:0] {
    CCU_OFF      = 4'b0000,
    CCU_CAP_FALL = 4'b0100,
    CCU_CAP_RISE = 4'b0101,
    CCU_CAP_4TH  = 4'b0110,
    CCU_CAP_16TH = 4'b0111,
    CCU_CMP_SET  = 4'b1000,
    CCU_CMP_CLR  = 4'b1001,
    CCU_CMP_SOFT = 4'b1010,
    CCU_CMP_TRIG = 4'b1011
  } ccu_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ccu_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ccu_wb_rsp_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } ccu_pin_drv_t;

endpackage : ccu_pkg

// *** logic/ccu_top.sv ***
// Behaviour
// (RL1) Mode 0000 disables the unit and resets its state and prescaler.
// (RL2) Capture modes: 0100 falling, 0101 rising, 0110 4th rising, 0111 16th rising.
// (RL3) Mode 1000: compare match drives pin high and sets event flag.
// (RL4) Mode 1001: compare match drives pin low and sets event flag.
// (RL5) Mode 1010: compare match only sets event flag, pin untouched.
// (RL6) Mode 1011: match sets flag, clears timer one, starts conversion if enabled.
// (RL7) Modes 11xx are PWM; control bits 5-4 hold duty low bits.
// (RL8) Control bits 7-6 are unimplemented and read zero.
// (RL9) Capture copies the 16-bit timer one count into the value pair.
// (RL10) Each capture sets event flag bit 2; only software clears it.
// (RL11) A new capture overwrites an unread earlier value.
// (RL12) With event pin as output, a port write can trigger capture.
// (RL13) Software makes the event pin an input for capture.
// (RL14) Software runs timer one synchronously when capture is used.
// (RL15) Capture mode change may raise a spurious flag; software clears it.
// (RL16) Prescaler counter clears when unit off or not capturing, so on reset.
// (RL17) Switching capture prescale directly keeps the counter and may set flag.
// (RL18) Compare mode compares value pair with timer one, acts on equality.
// (RL19) Event pin is port B bit 2 or bit 3 per location select.
// (RL20) Capture and compare use timer one, PWM uses timer two.
// (RL21) Writing zero to control forces compare output latch low.
// (RL22) Special event trigger clears timer one without overflow flag.
// (RL23) A match fires once per equal timer value, not while it holds.
`timescale 1ns/1ps
`include "ccu_cfg.svh"

module ccu_top
  import ccu_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire ccu_wb_req_t  wb_req,
  output ccu_wb_rsp_t       wb_rsp,
  input  wire logic [15:0]  timer_one_count,
  output logic              timer_one_clear,
  input  wire logic         adc_enable,
  output logic              adc_start,
  input  wire logic [7:0]   timer_two_count,
  input  wire logic [1:0]   timer_two_phase,
  input  wire logic         timer_two_period_match,
  input  wire logic         port_b_bit2_in,
  output ccu_pin_drv_t      port_b_bit2,
  input  wire logic         port_b_bit3_in,
  output ccu_pin_drv_t      port_b_bit3
);

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m[3:2] == 2'b01);
  endfunction : is_capture

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m[3:2] == 2'b10);
  endfunction : is_compare

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'b11);
  endfunction : is_pwm

  // Reset release
  logic        rst_s1;
  logic        rst_n_sync;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_s1     <= 1'b1;
      rst_n_sync <= rst_s1;
    end
  end

  // Registers
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [7:0]  ctrl;
  logic [7:0]  pincfg;
  logic [15:0] value;
  logic [1:0]  duty_latch;
  logic        cmp_out;
  logic [3:0]  presc_cnt;
  logic [15:0] last_hit;
  logic        hit_valid;

  logic [3:0]  mode;
  logic [7:0]  idx;
  logic        bus_req;
  logic        wr;
  logic        cap_fire;
  logic        cmp_fire;
  logic        cmp_eq;
  logic        ack_q;
  logic [31:0] rdat_q;

  assign mode    = ctrl[3:0];
  assign idx     = wb_req.adr[9:2];
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign wr      = bus_req && wb_req.we && ack_q && wb_req.sel[0];
  assign wb_rsp  = '{ack: ack_q, dat: rdat_q};

  // Bus answer, one cycle after request
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req && !ack_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      rdat_q <= 32'h0000_0000;
    else if (bus_req && !ack_q && !wb_req.we)
    begin
      unique case (idx)
        `CCU_IDX_FLAGS:   rdat_q <= {24'h00_0000, flags};
        `CCU_IDX_ENABLES: rdat_q <= {24'h00_0000, enables};
        `CCU_IDX_CTRL:    rdat_q <= {24'h00_0000, ctrl & `CCU_CTRL_MASK}; // [RL8]
        `CCU_IDX_VAL_LO:  rdat_q <= {24'h00_0000, value[7:0]};
        `CCU_IDX_VAL_HI:  rdat_q <= {24'h00_0000, value[15:8]};
        `CCU_IDX_PINCFG:  rdat_q <= {24'h00_0000, pincfg};
        default:          rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      ctrl <= `CCU_RST_CTRL;
    else if (wr && idx == `CCU_IDX_CTRL)
      ctrl <= wb_req.dat[7:0] & `CCU_CTRL_MASK; // [RL8]
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      enables <= `CCU_RST_ENABLES;
    else if (wr && idx == `CCU_IDX_ENABLES)
      enables <= wb_req.dat[7:0] & `CCU_ENABLES_MASK;
  end

  // Pin location, direction and port data latch
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      pincfg <= `CCU_RST_PINCFG;
    else if (wr && idx == `CCU_IDX_PINCFG)
      pincfg <= wb_req.dat[7:0] & `CCU_PINCFG_MASK;
  end

  // Pin synchronisers
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      pin_s1 <= 2'b00;
      pin_s2 <= 2'b00;
    end
    else
    begin
      pin_s1 <= {port_b_bit3_in, port_b_bit2_in};
      pin_s2 <= pin_s1;
    end
  end

  // Event pin routing
  logic pin_sel3;
  logic pin_dir;
  logic pin_dat;
  logic pin_level;
  logic pin_prev;
  logic pin_rise;
  logic pin_fall;

  assign pin_sel3  = !pincfg[`CCU_PIN_SEL_BIT]; // [RL19]
  assign pin_dir   = pin_sel3 ? pincfg[`CCU_DIR3_BIT] : pincfg[`CCU_DIR2_BIT];
  assign pin_dat   = pin_sel3 ? pincfg[`CCU_DAT3_BIT] : pincfg[`CCU_DAT2_BIT];
  assign pin_level = pin_dir ? (pin_sel3 ? pin_s2[1] : pin_s2[0]) : pin_dat; // [RL12]
  assign pin_rise  = pin_level && !pin_prev;
  assign pin_fall  = !pin_level && pin_prev;

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_level;
  end

  // Capture prescaler, kept across prescale changes
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      presc_cnt <= 4'h0;
    else if (!is_capture(mode))
      presc_cnt <= 4'h0; // [RL1] [RL16] [RL17]
    else if (pin_rise)
      presc_cnt <= presc_cnt + 4'h1;
  end

  always_comb
  begin
    unique case (mode)
      CCU_CAP_FALL: cap_fire = pin_fall; // [RL2]
      CCU_CAP_RISE: cap_fire = pin_rise;
      CCU_CAP_4TH:  cap_fire = pin_rise && presc_cnt[1:0] == `CCU_PS4_LAST;
      CCU_CAP_16TH: cap_fire = pin_rise && presc_cnt == `CCU_PS16_LAST;
      default:      cap_fire = 1'b0;
    endcase
  end

  // Compare against timer one, once per equal count
  assign cmp_eq   = is_compare(mode) && value == timer_one_count; // [RL18] [RL20]
  assign cmp_fire = cmp_eq && !(hit_valid && last_hit == timer_one_count); // [RL23]

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      hit_valid <= 1'b0;
      last_hit  <= `CCU_RST_VALUE;
    end
    else if (!cmp_eq)
      hit_valid <= 1'b0;
    else
    begin
      hit_valid <= 1'b1;
      last_hit  <= timer_one_count;
    end
  end

  // Value register pair
  logic wr_lo;
  logic wr_hi;

  assign wr_lo = wr && idx == `CCU_IDX_VAL_LO;
  assign wr_hi = wr && idx == `CCU_IDX_VAL_HI && !is_pwm(mode);

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      value <= `CCU_RST_VALUE;
    else if (cap_fire)
      value <= timer_one_count; // [RL9] [RL11] [RL20]
    else
    begin
      if (wr_lo)
        value[7:0] <= wb_req.dat[7:0];
      if (wr_hi)
        value[15:8] <= wb_req.dat[7:0];
      else if (is_pwm(mode) && timer_two_period_match)
        value[15:8] <= value[7:0]; // [RL7]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      duty_latch <= 2'b00;
    else if (is_pwm(mode) && timer_two_period_match)
      duty_latch <= ctrl[`CCU_DUTY_LSB +: 2]; // [RL7]
  end

  // Compare and PWM output latch
  logic pwm_end;
  logic duty_zero;

  assign duty_zero = value[7:0] == 8'h00 && ctrl[`CCU_DUTY_LSB +: 2] == 2'b00;
  assign pwm_end   = {value[15:8], duty_latch} == {timer_two_count, timer_two_phase};

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      cmp_out <= 1'b0;
    else if (mode == CCU_OFF)
      cmp_out <= 1'b0; // [RL1] [RL21]
    else if (cmp_fire && mode == CCU_CMP_SET)
      cmp_out <= 1'b1; // [RL3]
    else if (cmp_fire && mode == CCU_CMP_CLR)
      cmp_out <= 1'b0; // [RL4]
    else if (is_pwm(mode) && timer_two_period_match)
      cmp_out <= !duty_zero; // [RL20]
    else if (is_pwm(mode) && pwm_end)
      cmp_out <= 1'b0;
  end

  // Event flags, hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      flags <= `CCU_RST_FLAGS;
    else
    begin
      if (wr && idx == `CCU_IDX_FLAGS)
        flags <= wb_req.dat[7:0] & `CCU_FLAGS_MASK;
      if (cap_fire || cmp_fire)
        flags[`CCU_FLAG_BIT] <= 1'b1; // [RL10] [RL15] [RL3] [RL4] [RL5] [RL6]
    end
  end

  // Special event trigger
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      timer_one_clear <= 1'b0;
      adc_start       <= 1'b0;
    end
    else
    begin
      timer_one_clear <= cmp_fire && mode == CCU_CMP_TRIG; // [RL6] [RL22]
      adc_start       <= cmp_fire && mode == CCU_CMP_TRIG && adc_enable; // [RL6]
    end
  end

  // Pin drivers, enable low while driving
  logic drive_latch;

  assign drive_latch = is_compare(mode) || is_pwm(mode);

  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      port_b_bit2 <= '{out: 1'b0, oe_n: 1'b1};
      port_b_bit3 <= '{out: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      port_b_bit2.oe_n <= pincfg[`CCU_DIR2_BIT];
      port_b_bit3.oe_n <= pincfg[`CCU_DIR3_BIT];
      port_b_bit2.out  <= (drive_latch && !pin_sel3) ? cmp_out : pincfg[`CCU_DAT2_BIT];
      port_b_bit3.out  <= (drive_latch && pin_sel3) ? cmp_out : pincfg[`CCU_DAT3_BIT]; // [RL19]
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_sync);

  sequence s_trig_hit;
    cmp_fire && mode == CCU_CMP_TRIG;
  endsequence

  sequence s_trig_out;
    timer_one_clear && (adc_start == $past(adc_enable));
  endsequence

  chk_off_clears: assert property (mode == CCU_OFF |=> presc_cnt == 4'h0 && !cmp_out) // [RL1]
    else $error("off mode did not clear state");
  chk_fall_event: assert property (mode == CCU_CAP_FALL && pin_fall |-> cap_fire) // [RL2]
    else $error("falling edge missed");
  chk_cap_16th: assert property (mode == CCU_CAP_16TH && cap_fire |-> presc_cnt == 4'hf) // [RL2]
    else $error("16th edge capture at wrong count");
  chk_cap_copy: assert property (cap_fire |=> value == $past(timer_one_count)) // [RL9]
    else $error("capture value wrong");
  chk_cap_flag: assert property (cap_fire |=> flags[2]) // [RL10]
    else $error("capture flag not set");
  chk_match_high: assert property (cmp_fire && mode == CCU_CMP_SET |=> cmp_out) // [RL3]
    else $error("pin not set on match");
  chk_match_low: assert property (cmp_fire && mode == CCU_CMP_CLR |=> !cmp_out) // [RL4]
    else $error("pin not cleared on match");
  chk_soft_keep: assert property (cmp_fire && mode == CCU_CMP_SOFT |=> $stable(cmp_out)) // [RL5]
    else $error("pin moved in flag only mode");
  chk_trig_out: assert property (s_trig_hit |=> s_trig_out) // [RL6]
    else $error("special trigger missing");
  chk_trig_only: assert property (timer_one_clear |-> $past(cmp_fire)) // [RL22]
    else $error("timer clear without match");
  chk_once_match: assert property (cmp_fire ##1 $stable(timer_one_count) |-> !cmp_fire) // [RL23]
    else $error("repeated match on same count");
  chk_ctrl_zero: assert property (wb_rsp.ack && !wb_req.we && idx == `CCU_IDX_CTRL |-> wb_rsp.dat[7:6] == 2'b00) // [RL8]
    else $error("control upper bits not zero");

endmodule : ccu_top

// *** verif/ccu_far_side.sv ***
`timescale 1ns/1ps

module ccu_far_side
  import ccu_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [15:0]  load_val,
  input  wire logic [15:0]  stop_at,
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic         level,
  input  wire logic         on_bit2,
  input  wire ccu_pin_drv_t drv2,
  input  wire ccu_pin_drv_t drv3,
  output logic [15:0]       count,
  output logic              pin2,
  output logic              pin3
);
  // Timer one on the same clock, never asynchronous
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      count <= 16'h0000;
    else if (load)
      count <= load_val;
    else if (clr)
      count <= 16'h0000; // Cleared, no overflow raised
    else if (run && count != stop_at)
      count <= count + 16'h0001;

  // Pulled-down line; a pin the unit drives wins
  assign pin2 = !drv2.oe_n ? drv2.out : (on_bit2 && level);
  assign pin3 = !drv3.oe_n ? drv3.out : (!on_bit2 && level);
endmodule : ccu_far_side

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

module tb_top
  import ccu_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rstn = 1'b0;
  ccu_wb_req_t  req = '0;
  ccu_wb_rsp_t  rsp;
  ccu_pin_drv_t drv2, drv3;
  logic         load = 1'b0, run = 1'b0, level = 1'b0, on_bit2 = 1'b0, adc_en = 1'b0;
  logic         t1_clr, adc_st, pin2, pin3;
  logic [15:0]  count, load_val = 16'h0000, stop_at = 16'h0000, v;
  logic [31:0]  rd;
  int           fail_count = 0, cmp_count = 0, cyc_cnt = 0, n_clr = 0, n_adc = 0, c0, a0;
  ccu_mode_t    cap_m [4] = '{CCU_CAP_FALL, CCU_CAP_RISE, CCU_CAP_4TH, CCU_CAP_16TH};
  int           cap_n [4] = '{1, 1, 4, 16};
  ccu_mode_t    cmp_m [5] = '{CCU_CMP_SET, CCU_CMP_SOFT, CCU_CMP_CLR, CCU_CMP_TRIG, CCU_CMP_SET};
  logic         pin_exp = 1'b0;

  ccu_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .wb_req(req), .wb_rsp(rsp),
    .timer_one_count(count), .timer_one_clear(t1_clr), .adc_enable(adc_en),
    .adc_start(adc_st), .timer_two_count(8'h00), .timer_two_phase(2'h0),
    .timer_two_period_match(1'b0), .port_b_bit2_in(pin2), .port_b_bit2(drv2),
    .port_b_bit3_in(pin3), .port_b_bit3(drv3));

  ccu_far_side u_far (.ref_clk(ref_clk), .rstn(rstn), .load(load), .load_val(load_val),
    .stop_at(stop_at), .run(run), .clr(t1_clr), .level(level), .on_bit2(on_bit2),
    .drv2(drv2), .drv3(drv3), .count(count), .pin2(pin2), .pin3(pin3));

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc_cnt++;
    n_clr += t1_clr;
    n_adc += adc_st;
    if (cyc_cnt == 40000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic exp_pin(input ccu_mode_t m, input logic prev);
    if (m == CCU_CMP_SET)
      return 1'b1;
    if (m == CCU_CMP_CLR)
      return 1'b0;
    return prev;
  endfunction : exp_pin

  function automatic int exp_trig(input ccu_mode_t m, input logic en);
    return (m == CCU_CMP_TRIG) ? 2 + int'(en) : 0;
  endfunction : exp_trig

  // Classic single cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b1, we, {2'b00, idx, 2'b00}, 4'h1, {24'h00_0000, d}};
    do @(posedge ref_clk); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rchk

  task automatic tset(input logic [15:0] lv, input logic [15:0] st);
    load <= 1'b1;
    load_val <= lv;
    stop_at <= st;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask : tset

  task automatic pulses(input int n);
    repeat (n)
    begin
      level <= 1'b1;
      repeat (8) @(posedge ref_clk);
      level <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask : pulses

  initial
  begin
    v = 16'($urandom(32'h05e5_a1fd));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk(8'h0c, 32'h0000_0000);
    rchk(8'h17, 32'h0000_0000);
    rchk(8'h8c, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wb(1'b1, 8'h17, 8'hff);
    rchk(8'h17, 32'h0000_003f);
    wb(1'b1, 8'h17, 8'h00);
    // Capture: partial count, off, on again, then two full events
    for (int i = 0; i < 4; i++)
    begin
      on_bit2 <= i[0];
      wb(1'b1, 8'h20, {7'h06, i[0]});
      wb(1'b1, 8'h17, 8'(cap_m[i]));
      pulses(1);
      wb(1'b1, 8'h17, 8'h00);
      wb(1'b1, 8'h17, 8'(cap_m[i]));
      wb(1'b1, 8'h0c, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
        v = 16'($urandom);
        tset(v, v);
        pulses(cap_n[i] - 1);
        rchk(8'h0c, 32'(k * 4));
        pulses(1);
        rchk(8'h0c, 32'h0000_0004);
      end
      rchk(8'h15, {24'h00_0000, v[7:0]});
      rchk(8'h16, {24'h00_0000, v[15:8]});
      wb(1'b1, 8'h0c, 8'h00);
    end
    // Direct prescale switch keeps the count
    wb(1'b1, 8'h17, 8'h00);
    wb(1'b1, 8'h17, 8'h06);
    wb(1'b1, 8'h0c, 8'h00);
    pulses(2);
    wb(1'b1, 8'h17, 8'h07);
    pulses(13);
    rchk(8'h0c, 32'h0000_0000);
    pulses(1);
    rchk(8'h0c, 32'h0000_0004);
    // Port latch write on an output pin
    wb(1'b1, 8'h17, 8'h00);
    wb(1'b1, 8'h20, 8'h04);
    wb(1'b1, 8'h17, 8'h05);
    wb(1'b1, 8'h0c, 8'h00);
    v = 16'($urandom);
    tset(v, v);
    wb(1'b1, 8'h20, 8'h24);
    repeat (8) @(posedge ref_clk);
    rchk(8'h0c, 32'h0000_0004);
    rchk(8'h15, {24'h00_0000, v[7:0]});
    // Compare modes, switched directly so the pin latch carries over
    wb(1'b1, 8'h17, 8'h00);
    wb(1'b1, 8'h20, 8'h04);
    for (int i = 0; i < 5; i++)
    begin
      v = 16'((i + 1) * 512 + $urandom_range(200));
      adc_en <= 1'($urandom);
      tset(v - 16'h0014, v);
      wb(1'b1, 8'h15, v[7:0]);
      wb(1'b1, 8'h16, v[15:8]);
      wb(1'b1, 8'h17, 8'(cmp_m[i]));
      wb(1'b1, 8'h0c, 8'h00);
      c0 = n_clr;
      a0 = n_adc;
      run <= 1'b1;
      repeat (40) @(posedge ref_clk);
      run <= 1'b0;
      rchk(8'h0c, 32'h0000_0004);
      pin_exp = exp_pin(cmp_m[i], pin_exp);
      chk(drv3.out, pin_exp);
      chk(drv3.oe_n, 1'b0);
      chk({drv2.out, drv2.oe_n}, 32'h0000_0001);
      chk((n_clr - c0) * 2 + (n_adc - a0), exp_trig(cmp_m[i], adc_en));
      chk(count == v, cmp_m[i] != CCU_CMP_TRIG);
      wb(1'b1, 8'h0c, 8'h00);
      repeat (8) @(posedge ref_clk);
      rchk(8'h0c, 32'h0000_0000);
    end
    wb(1'b1, 8'h17, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk(drv3.out, 1'b0);
    wb(1'b1, 8'h17, 8'h0a);
    repeat (4) @(posedge ref_clk);
    chk(drv3.out, 1'b0);
    rchk(8'h0c, 32'h0000_0004);
    print_verdict();
  end
endmodule : tb_top
